// file: rtl/alu_add_if.sv
// Operand and result bundle between the unit and its adder
interface alu_add_if;
    import alu_pkg::*;

    byte_t x;
    byte_t y;
    logic sub;
    logic cin;
    byte_t res;
    logic c;
    logic ac;
    logic ov;
    logic z;

    modport core (input x, y, sub, cin, output res, c, ac, ov, z);
    modport user (output x, y, sub, cin, input res, c, ac, ov, z);
endinterface

// file: rtl/alu_adder.sv
// Two's-complement adder with carry, half-carry, overflow and zero
module alu_adder (
    alu_add_if.core a
);
    import alu_pkg::*;

    byte_t y_eff;
    logic c_in;
    logic [4:0] lo_sum;
    logic [8:0] full_sum;

    // Subtraction is x plus inverted y plus inverted borrow
    assign y_eff = a.sub ? ~a.y : a.y;
    assign c_in = a.sub ? ~a.cin : a.cin;
    assign lo_sum = {1'b0, a.x[NIBBLE_TOP:0]} + {1'b0, y_eff[NIBBLE_TOP:0]}
                  + {4'h0, c_in};
    assign full_sum = {1'b0, a.x} + {1'b0, y_eff} + {8'h00, c_in};

    assign a.res = full_sum[7:0];
    // Subtraction reports borrow, which is the missing carry
    assign a.c = a.sub ? ~full_sum[8] : full_sum[8];
    assign a.ac = a.sub ? ~lo_sum[4] : lo_sum[4];
    assign a.ov = (a.x[SIGN_BIT] == y_eff[SIGN_BIT])
               && (full_sum[SIGN_BIT] != a.x[SIGN_BIT]);
    assign a.z = (full_sum[7:0] == BYTE_ZERO);
endmodule

// file: rtl/alu_pkg.sv
// Shared types and constants of the 8-bit arithmetic unit
package alu_pkg;

    typedef logic [7:0] byte_t;

    // Operation codes issued by the instruction decoder
    typedef enum logic [4:0] {
        OP_NOP     = 5'h00,
        OP_ADD_AI  = 5'h01,
        OP_ADD_AM  = 5'h02,
        OP_ADD_MA  = 5'h03,
        OP_ADDC_AM = 5'h04,
        OP_ADDC_MA = 5'h05,
        OP_ADDC_A  = 5'h06,
        OP_ADDC_M  = 5'h07,
        OP_NADD_AM = 5'h08,
        OP_NADD_MA = 5'h09,
        OP_SUB_AI  = 5'h0a,
        OP_SUB_AM  = 5'h0b,
        OP_SUB_MA  = 5'h0c,
        OP_SUBC_AM = 5'h0d,
        OP_SUBC_MA = 5'h0e,
        OP_SUBC_A  = 5'h0f,
        OP_SUBC_M  = 5'h10,
        OP_INC_M   = 5'h11,
        OP_DEC_M   = 5'h12,
        OP_CLEAR_M = 5'h13
    } op_t;

    // Values after reset
    localparam byte_t WREG_RST = 8'h00;
    localparam byte_t MEM_WDATA_RST = 8'h00;
    localparam logic FLAG_RST = 1'b0;

    // Fixed operand constants
    localparam byte_t BYTE_ZERO = 8'h00;
    localparam byte_t BYTE_ONE = 8'h01;

    // Field positions inside a byte
    localparam int SIGN_BIT = 7;
    localparam int NIBBLE_TOP = 3;

    // Cycles from an accepted operation to its registered result
    localparam int RESULT_LAT_CYC = 1;

endpackage

// file: rtl/arith_alu_8bit.sv
// Arithmetic unit: add, subtract, carry forms, inc, dec, clear
module arith_alu_8bit (
    input wire logic CORE_CLK,
    input wire logic RSTN,
    input wire logic OP_VALID,
    input wire alu_pkg::op_t OP_CODE,
    input wire alu_pkg::byte_t IMM_DATA,
    input wire alu_pkg::byte_t MEM_RDATA,
    input wire logic WREG_LOAD,
    input wire alu_pkg::byte_t WREG_LOAD_DATA,
    output logic OP_DONE,
    output alu_pkg::byte_t WORK_REG,
    output alu_pkg::byte_t MEM_WDATA,
    output logic MEM_WE,
    output logic ZERO_FLAG,
    output logic CARRY_FLAG,
    output logic HALF_CARRY_FLAG,
    output logic SIGNED_RANGE_FLAG
);
    import alu_pkg::*;

    // ------------------------------------------------------------
    // Operation decode
    // ------------------------------------------------------------
    op_t op;
    logic op_legal;
    logic take;
    logic x_mem;
    logic y_imm;
    logic y_mem;
    logic y_zero;
    logic y_one;
    logic is_sub;
    logic use_c;
    logic dst_mem;
    logic is_clear;

    assign op = OP_CODE;
    // Codes outside the table are ignored rather than guessed at
    assign op_legal = (op >= OP_ADD_AI) && (op <= OP_CLEAR_M);
    assign take = OP_VALID && op_legal;
    assign is_clear = (op == OP_CLEAR_M);

    assign x_mem = op inside {OP_ADD_MA, OP_ADDC_MA, OP_ADDC_M,
                              OP_NADD_AM, OP_SUB_MA, OP_SUBC_MA,
                              OP_SUBC_M, OP_INC_M, OP_DEC_M};
    assign y_imm = op inside {OP_ADD_AI, OP_SUB_AI};
    assign y_mem = op inside {OP_ADD_AM, OP_ADDC_AM, OP_NADD_MA,
                              OP_SUB_AM, OP_SUBC_AM};
    assign y_zero = op inside {OP_ADDC_A, OP_ADDC_M,
                               OP_SUBC_A, OP_SUBC_M};
    assign y_one = op inside {OP_INC_M, OP_DEC_M};
    // Negate-then-add is a subtraction with swapped operands
    assign is_sub = op inside {OP_NADD_AM, OP_NADD_MA, OP_SUB_AI,
                               OP_SUB_AM, OP_SUB_MA, OP_SUBC_AM,
                               OP_SUBC_MA, OP_SUBC_A, OP_SUBC_M,
                               OP_DEC_M};
    assign use_c = op inside {OP_ADDC_AM, OP_ADDC_MA, OP_ADDC_A,
                              OP_ADDC_M, OP_SUBC_AM, OP_SUBC_MA,
                              OP_SUBC_A, OP_SUBC_M};
    assign dst_mem = op inside {OP_ADD_MA, OP_ADDC_MA, OP_ADDC_M,
                                OP_NADD_MA, OP_SUB_MA, OP_SUBC_MA,
                                OP_SUBC_M, OP_INC_M, OP_DEC_M,
                                OP_CLEAR_M};

    // ------------------------------------------------------------
    // Operand selection and adder
    // ------------------------------------------------------------
    alu_add_if add_bus ();

    assign add_bus.x = x_mem ? MEM_RDATA : WORK_REG;
    assign add_bus.y = y_imm ? IMM_DATA :
                       y_mem ? MEM_RDATA :
                       y_zero ? BYTE_ZERO :
                       y_one ? BYTE_ONE : WORK_REG;
    assign add_bus.sub = is_sub;
    assign add_bus.cin = use_c & CARRY_FLAG;

    alu_adder adder_u (
        .a (add_bus.core)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    byte_t wreg_d;
    byte_t mem_wdata_d;
    logic mem_we_d;
    logic flags_upd;
    logic z_d;
    logic c_d;
    logic ac_d;
    logic ov_d;

    // A load from the sequencer only lands when no operation is taken
    assign wreg_d = (take && !dst_mem) ? add_bus.res :
                    (!take && WREG_LOAD) ? WREG_LOAD_DATA : WORK_REG;
    assign mem_wdata_d = !(take && dst_mem) ? MEM_WDATA :
                         is_clear ? BYTE_ZERO : add_bus.res;
    assign mem_we_d = take && dst_mem;
    // Clear writes memory but leaves every flag as it was
    assign flags_upd = take && !is_clear;
    assign z_d = flags_upd ? add_bus.z : ZERO_FLAG;
    assign c_d = flags_upd ? add_bus.c : CARRY_FLAG;
    assign ac_d = flags_upd ? add_bus.ac : HALF_CARRY_FLAG;
    assign ov_d = flags_upd ? add_bus.ov : SIGNED_RANGE_FLAG;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            WORK_REG <= WREG_RST;
            MEM_WDATA <= MEM_WDATA_RST;
            MEM_WE <= 1'b0;
            OP_DONE <= 1'b0;
        end else begin
            WORK_REG <= wreg_d;
            MEM_WDATA <= mem_wdata_d;
            MEM_WE <= mem_we_d;
            OP_DONE <= take;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            ZERO_FLAG <= FLAG_RST;
            CARRY_FLAG <= FLAG_RST;
            HALF_CARRY_FLAG <= FLAG_RST;
            SIGNED_RANGE_FLAG <= FLAG_RST;
        end else begin
            ZERO_FLAG <= z_d;
            CARRY_FLAG <= c_d;
            HALF_CARRY_FLAG <= ac_d;
            SIGNED_RANGE_FLAG <= ov_d;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!RSTN);

    sequence issued(op_t o);
        OP_VALID && (OP_CODE == o);
    endsequence

    sequence reg_written(byte_t v);
        (WORK_REG == v) && !MEM_WE && OP_DONE;
    endsequence

    sequence mem_written(byte_t v);
        MEM_WE && (MEM_WDATA == v) && OP_DONE;
    endsequence

    add_imm_a: assert property (issued(OP_ADD_AI) |=>
        reg_written(8'($past(WORK_REG) + $past(IMM_DATA))))
        else $error("add immediate result wrong");

    add_src_a: assert property (issued(OP_ADD_AM) |=>
        reg_written(8'($past(WORK_REG) + $past(MEM_RDATA))))
        else $error("add memory source result wrong");

    add_dst_a: assert property (issued(OP_ADD_MA) |=>
        mem_written(8'($past(WORK_REG) + $past(MEM_RDATA)))
        && $stable(WORK_REG))
        else $error("add memory destination result wrong");

    addc_reg_a: assert property (issued(OP_ADDC_AM) |=>
        reg_written(8'($past(WORK_REG) + $past(MEM_RDATA)
        + {7'h00, $past(CARRY_FLAG)})))
        else $error("add with carry to register wrong");

    addc_mem_a: assert property (issued(OP_ADDC_MA) |=>
        mem_written(8'($past(WORK_REG) + $past(MEM_RDATA)
        + {7'h00, $past(CARRY_FLAG)})))
        else $error("add with carry to memory wrong");

    carry_reg_a: assert property (issued(OP_ADDC_A) |=>
        reg_written(8'($past(WORK_REG) + {7'h00, $past(CARRY_FLAG)})))
        else $error("carry add to register wrong");

    carry_mem_a: assert property (issued(OP_ADDC_M) |=>
        mem_written(8'($past(MEM_RDATA) + {7'h00, $past(CARRY_FLAG)})))
        else $error("carry add to memory wrong");

    nadd_reg_a: assert property (issued(OP_NADD_AM) |=>
        reg_written(8'($past(MEM_RDATA) - $past(WORK_REG))))
        else $error("negate-add to register wrong");

    nadd_mem_a: assert property (issued(OP_NADD_MA) |=>
        mem_written(8'($past(WORK_REG) - $past(MEM_RDATA))))
        else $error("negate-add to memory wrong");

    sub_imm_a: assert property (issued(OP_SUB_AI) |=>
        reg_written(8'($past(WORK_REG) - $past(IMM_DATA)))
        && (CARRY_FLAG == ($past(WORK_REG) < $past(IMM_DATA))))
        else $error("subtract immediate wrong");

    sub_src_a: assert property (issued(OP_SUB_AM) |=>
        reg_written(8'($past(WORK_REG) - $past(MEM_RDATA))))
        else $error("subtract memory source wrong");

    sub_dst_a: assert property (issued(OP_SUB_MA) |=>
        mem_written(8'($past(MEM_RDATA) - $past(WORK_REG))))
        else $error("subtract memory destination wrong");

    subc_reg_a: assert property (issued(OP_SUBC_AM) |=>
        reg_written(8'($past(WORK_REG) - $past(MEM_RDATA)
        - {7'h00, $past(CARRY_FLAG)})))
        else $error("subtract with borrow to register wrong");

    subc_mem_a: assert property (issued(OP_SUBC_MA) |=>
        mem_written(8'($past(MEM_RDATA) - $past(WORK_REG)
        - {7'h00, $past(CARRY_FLAG)})))
        else $error("subtract with borrow to memory wrong");

    borrow_reg_a: assert property (issued(OP_SUBC_A) |=>
        reg_written(8'($past(WORK_REG) - {7'h00, $past(CARRY_FLAG)})))
        else $error("borrow subtract from register wrong");

    borrow_mem_a: assert property (issued(OP_SUBC_M) |=>
        mem_written(8'($past(MEM_RDATA) - {7'h00, $past(CARRY_FLAG)})))
        else $error("borrow subtract from memory wrong");

    inc_mem_a: assert property (issued(OP_INC_M) |=>
        mem_written(8'($past(MEM_RDATA) + 8'h01))
        && (CARRY_FLAG == ($past(MEM_RDATA) == 8'hff))
        && (HALF_CARRY_FLAG == ($past(MEM_RDATA[3:0]) == 4'hf)))
        else $error("increment wrong");

    dec_mem_a: assert property (issued(OP_DEC_M) |=>
        mem_written(8'($past(MEM_RDATA) - 8'h01))
        && (CARRY_FLAG == ($past(MEM_RDATA) == 8'h00))
        && (SIGNED_RANGE_FLAG == ($past(MEM_RDATA) == 8'h80)))
        else $error("decrement wrong");

    clear_keep_a: assert property (issued(OP_CLEAR_M) |=>
        mem_written(8'h00) && $stable(ZERO_FLAG) && $stable(CARRY_FLAG)
        && $stable(HALF_CARRY_FLAG) && $stable(SIGNED_RANGE_FLAG))
        else $error("clear changed flags or data");

    add_carry_a: assert property (issued(OP_ADD_AM) |=>
        (CARRY_FLAG == ((9'($past(WORK_REG)) + 9'($past(MEM_RDATA)))
        > 9'h0ff)) && (HALF_CARRY_FLAG == ((5'($past(WORK_REG[3:0]))
        + 5'($past(MEM_RDATA[3:0]))) > 5'h0f)))
        else $error("add carry or half-carry wrong");

    add_range_a: assert property (issued(OP_ADD_AM) |=>
        (SIGNED_RANGE_FLAG == (($past(WORK_REG[7]) == $past(MEM_RDATA[7]))
        && (WORK_REG[7] != $past(WORK_REG[7]))))
        && (ZERO_FLAG == (WORK_REG == 8'h00)))
        else $error("overflow or zero flag wrong");

    idle_hold_a: assert property (!OP_VALID && !WREG_LOAD |=>
        $stable(WORK_REG) && !MEM_WE && !OP_DONE && $stable(CARRY_FLAG))
        else $error("state moved without an operation");
endmodule

// file: test/mem_byte_model.sv
// One addressed data-memory byte as the core's sequencer presents it
module mem_byte_model
    import alu_pkg::*;
(
    input wire logic clk,
    input wire logic rd_en,
    input wire logic we,
    input wire byte_t wdata,
    input wire logic set_en,
    input wire byte_t set_data,
    output byte_t rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    byte_t mem;

    initial begin
        mem = 8'h00;
    end

    // Write strobe wins; the bench never presets in the strobe cycle
    always @(posedge clk) begin
        if (we) begin
            mem <= wdata;
        end else if (set_en) begin
            mem <= set_data;
        end
    end

    // Outside a read the bus carries garbage, never the stored byte
    assign rdata = rd_en ? mem : ~mem;
endmodule

// file: test/testbench.sv
// Self-checking bench of the 8-bit arithmetic unit
module testbench;
    import alu_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rstn_n, vld, ld, we, done, set_en;
    logic z, c, ac, ov;
    op_t code;
    byte_t imm, ld_d, rd, wd, wr, set_d, a, m, lastw;
    logic [3:0] f;
    logic [20:0] q[$];
    int n_errors, checks_done, i;

    arith_alu_8bit u_arith_alu_8bit (.CORE_CLK(clk), .RSTN(rstn_n),
        .OP_VALID(vld), .OP_CODE(code), .IMM_DATA(imm), .MEM_RDATA(rd),
        .WREG_LOAD(ld), .WREG_LOAD_DATA(ld_d), .OP_DONE(done),
        .WORK_REG(wr), .MEM_WDATA(wd), .MEM_WE(we), .ZERO_FLAG(z),
        .CARRY_FLAG(c), .HALF_CARRY_FLAG(ac), .SIGNED_RANGE_FLAG(ov));
    mem_byte_model u_mem_byte_model (.clk(clk), .rd_en(vld), .we(we),
        .wdata(wd), .set_en(set_en), .set_data(set_d), .rdata(rd));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic check(string what, logic [20:0] got, logic [20:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic summarize();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Every result must be announced and must match the oldest note
    always @(negedge clk) begin
        if (done === 1'b1) begin
            if (q.size() == 0) begin
                check("spurious done", 21'h1, 21'h0);
            end else begin
                check("result", {we, wr, wd, z, c, ac, ov}, q.pop_front());
            end
        end else if (we !== 1'b0) begin
            check("stray write", 21'h1, 21'h0);
        end
    end

    task automatic do_reset();
        @(posedge clk);
        #2 rstn_n = 1'b0;
        repeat (8) @(posedge clk);
        check("reset", {done, we, wr, wd, z, c, ac, ov}, 21'h0);
        #2 rstn_n = 1'b1;
        a = 8'h00;
        lastw = 8'h00;
        f = 4'h0;
    endtask

    task automatic idle(logic s, byte_t sv, logic l, byte_t d);
        @(posedge clk);
        #2 vld = 1'b0;
        code = op_t'(5'($urandom));
        set_en = s;
        set_d = sv;
        ld = l;
        ld_d = d;
        if (s) m = sv;
        if (l) a = d;
    endtask

    // Illegal code: no answer, so a load in the same cycle is taken
    task automatic bad(logic [4:0] op, byte_t d);
        @(posedge clk);
        #2 vld = 1'b1;
        code = op_t'(op);
        set_en = 1'b0;
        ld = 1'b1;
        ld_d = d;
        a = d;
    endtask

    task automatic do_op(op_t op, byte_t im);
        logic xm, s, dm, k;
        logic [1:0] ys, kc;
        logic [8:0] t;
        logic [4:0] h;
        byte_t x, y;
        @(posedge clk);
        #2 vld = 1'b1;
        code = op;
        imm = im;
        set_en = 1'b0;
        ld = 1'($urandom);
        ld_d = 8'($urandom);
        // Fields: x is memory, y select, subtract, carry-in kind, to memory
        case (op)
            OP_ADD_AI: {xm, ys, s, kc, dm} = 7'h20;
            OP_ADD_AM: {xm, ys, s, kc, dm} = 7'h00;
            OP_ADD_MA: {xm, ys, s, kc, dm} = 7'h01;
            OP_ADDC_AM: {xm, ys, s, kc, dm} = 7'h02;
            OP_ADDC_MA: {xm, ys, s, kc, dm} = 7'h03;
            OP_ADDC_A: {xm, ys, s, kc, dm} = 7'h32;
            OP_ADDC_M: {xm, ys, s, kc, dm} = 7'h73;
            OP_NADD_AM: {xm, ys, s, kc, dm} = 7'h58;
            OP_NADD_MA: {xm, ys, s, kc, dm} = 7'h09;
            OP_SUB_AI: {xm, ys, s, kc, dm} = 7'h28;
            OP_SUB_AM: {xm, ys, s, kc, dm} = 7'h08;
            OP_SUB_MA: {xm, ys, s, kc, dm} = 7'h59;
            OP_SUBC_AM: {xm, ys, s, kc, dm} = 7'h0a;
            OP_SUBC_MA: {xm, ys, s, kc, dm} = 7'h5b;
            OP_SUBC_A: {xm, ys, s, kc, dm} = 7'h3a;
            OP_SUBC_M: {xm, ys, s, kc, dm} = 7'h7b;
            OP_INC_M: {xm, ys, s, kc, dm} = 7'h75;
            OP_DEC_M: {xm, ys, s, kc, dm} = 7'h7d;
            default: {xm, ys, s, kc, dm} = 7'h01;
        endcase
        x = xm ? m : a;
        y = ys == 2'h0 ? m : ys == 2'h1 ? a : ys == 2'h2 ? im : 8'h00;
        k = kc[1] | (kc[0] & f[2]);
        if (s) begin
            t = {1'b0, x} - {1'b0, y} - {8'h00, k};
            h = {1'b0, x[3:0]} - {1'b0, y[3:0]} - {4'h0, k};
        end else begin
            t = {1'b0, x} + {1'b0, y} + {8'h00, k};
            h = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, k};
        end
        if (op == OP_CLEAR_M) begin
            t = 9'h000;
        end else begin
            f = {t[7:0] == 8'h00, t[8], h[4],
                 ((x[7] ^ s) == y[7]) && (t[7] != x[7])};
        end
        if (dm) begin
            m = t[7:0];
            lastw = t[7:0];
        end else begin
            a = t[7:0];
        end
        q.push_back({dm, a, lastw, f});
        // The stored byte changes one edge late; let it land first
        if (dm) idle(1'b0, 8'h00, 1'b0, 8'h00);
    endtask

    initial begin
        {vld, ld, set_en, imm, ld_d, set_d} = '0;
        code = OP_NOP;
        rstn_n = 1'b0;
        m = 8'h00;
        n_errors = 0;
        checks_done = 0;
        void'($urandom(84112));
        do_reset();
        // ----------------------------------------------------------
        // Directed edges, every code, refused codes
        // ----------------------------------------------------------
        idle(1'b1, 8'h01, 1'b1, 8'hff);
        do_op(OP_ADD_AM, 8'h00);
        for (i = 1; i <= 19; i++) begin
            idle(1'b1, 8'h80, 1'b1, 8'h7f);
            do_op(op_t'(5'(i)), 8'h80);
            idle(1'b1, 8'h0f, 1'b1, 8'h00);
            do_op(op_t'(5'(i)), 8'hff);
        end
        bad(5'h00, 8'h3c);
        bad(5'h14, 8'hc3);
        bad(5'h1f, 8'h5a);
        // ----------------------------------------------------------
        // Random traffic, back to back, mid-run reset
        // ----------------------------------------------------------
        for (i = 0; i < 400; i++) begin
            idle(1'($urandom), 8'($urandom), 1'($urandom), 8'($urandom));
            do_op(op_t'(5'($urandom_range(19, 1))), 8'($urandom));
            do_op(op_t'(5'($urandom_range(19, 1))), 8'($urandom));
        end
        idle(1'b0, 8'h00, 1'b0, 8'h00);
        do_reset();
        do_op(OP_SUBC_A, 8'h00);
        idle(1'b0, 8'h00, 1'b0, 8'h00);
        for (i = 0; i < 10 && q.size() != 0; i++) @(posedge clk);
        if (q.size() != 0) check("drain", 21'h1, 21'h0);
        @(posedge clk);
        summarize();
    end
endmodule
